// *** core/snp_cycle_timer.sv ***
// snp_cycle_timer: seconds, cycles and tick offset counters of cycle time.
// assumes tick is a one-cycle enable at the 24.576 MHz rate; ext_tick_pin
// is an asynchronous 8 kHz pin.
`timescale 1ns/1ns
module snp_cycle_timer
(
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic                  count_en,
  input  wire logic                  tick,
  input  wire logic                  ext_source,
  input  wire logic                  ext_tick_pin,
  input  wire logic                  sw_load,
  input  wire logic [31:0]           sw_value,
  input  wire logic                  rx_load,
  input  wire logic [31:0]           rx_value,
  output logic                       rollover,
  output logic [31:0]                value
);

  typedef struct packed {
    logic [2:0]                sync;
    snp_pkg::snp_cycle_time_s  ct;
    logic                      roll;
  } snp_ct_state_s;

  snp_ct_state_s s_q;
  snp_ct_state_s s_d;
  logic          ext_edge;
  logic          wrap;

  // sync[0] feeds only sync[1]
  assign ext_edge = s_q.sync[1] && !s_q.sync[2];

  // ==========================================================================
  // counting, loads take priority
  always_comb
  begin
    s_d      = s_q;
    s_d.sync = {s_q.sync[1:0], ext_tick_pin};
    s_d.roll = 1'b0;
    wrap     = 1'b0;
    if (count_en)
    begin
      if (ext_source)
      begin
        if (ext_edge)
        begin
          s_d.ct.offset = 12'h000;
          wrap          = 1'b1;
        end
        else if (tick && s_q.ct.offset != snp_pkg::OFFSET_LAST)
          s_d.ct.offset = s_q.ct.offset + 12'h001;
      end
      else if (tick)
      begin
        if (s_q.ct.offset == snp_pkg::OFFSET_LAST)
        begin
          s_d.ct.offset = 12'h000;
          wrap          = 1'b1;
        end
        else
          s_d.ct.offset = s_q.ct.offset + 12'h001;
      end
    end
    if (wrap)
    begin
      s_d.roll = 1'b1;
      if (s_q.ct.cycles == snp_pkg::CYCLE_LAST)
      begin
        s_d.ct.cycles  = 13'h0000;
        s_d.ct.seconds = s_q.ct.seconds + 7'h01;
      end
      else
        s_d.ct.cycles = s_q.ct.cycles + 13'h0001;
    end
    if (sw_load)
      s_d.ct = sw_value;
    else if (rx_load)
      s_d.ct = rx_value;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q    <= '0;
      s_q.ct <= snp_pkg::CYCLE_TIME_RST;
    end
    else
      s_q <= s_d;
  end

  assign rollover = s_q.roll;
  assign value    = s_q.ct;

endmodule // snp_cycle_timer

// *** core/snp_phy_req.sv ***
// snp_phy_req: holds one phy register request toward the phy until taken.
// assumes the phy side takes a request on a cycle with valid and ready high.
`timescale 1ns/1ns
module snp_phy_req
(
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic                  start,
  input  snp_pkg::snp_phy_req_s      start_req,
  output logic                       idle,
  output logic                       sent,
  output logic                       req_valid,
  input  wire logic                  req_ready,
  output snp_pkg::snp_phy_req_s      req
);

  typedef enum logic {SNP_IDLE, SNP_SEND} snp_req_e;

  typedef struct packed {
    snp_req_e              st;
    snp_pkg::snp_phy_req_s req;
  } snp_req_state_s;

  snp_req_state_s s_q;
  snp_req_state_s s_d;

  // ==========================================================================
  // one request at a time
  always_comb
  begin
    s_d = s_q;
    unique case (s_q.st)
      SNP_IDLE:
      begin
        if (start)
        begin
          s_d.st  = SNP_SEND;
          s_d.req = start_req;
        end
      end
      SNP_SEND:
      begin
        if (req_ready)
          s_d.st = SNP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign idle      = (s_q.st == SNP_IDLE);
  assign req_valid = (s_q.st == SNP_SEND);
  assign sent      = req_valid && req_ready;
  assign req       = s_q.req;

endmodule // snp_phy_req

// *** core/snp_pkg.sv ***
// snp_pkg: offsets, field positions, reset values and carriers of the
// node address, phy register access and cycle time registers.
// assumes an 8-bit byte address on the register port, 32-bit data.
package snp_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFS_NODE_ADDRESS = 8'hE8;
  localparam logic [7:0] OFS_PHY_ACCESS   = 8'hEC;
  localparam logic [7:0] OFS_CYCLE_TIME   = 8'hF0;

  // ==========================================================================
  // node address fields
  localparam int NA_VALID_BIT   = 31;
  localparam int NA_ROOT_BIT    = 30;
  localparam int NA_POWER_BIT   = 27;
  localparam int NA_BUS_LSB     = 6;
  localparam int NA_NODE_LSB    = 0;
  localparam logic [9:0] BUS_INDEX_RST = 10'h3FF;
  localparam logic [5:0] NODE_RST      = 6'h00;
  localparam logic [5:0] NODE_UNSET    = 6'h3F;

  // ==========================================================================
  // phy register access fields
  localparam int PA_DONE_BIT    = 31;
  localparam int PA_RDIDX_LSB   = 24;
  localparam int PA_RDVAL_LSB   = 16;
  localparam int PA_RDREQ_BIT   = 15;
  localparam int PA_WRREQ_BIT   = 14;
  localparam int PA_TGT_LSB     = 8;
  localparam int PA_WRVAL_LSB   = 0;

  // ==========================================================================
  // cycle time fields and moduli
  localparam int CT_SEC_LSB     = 25;
  localparam int CT_CYC_LSB     = 12;
  localparam logic [11:0] OFFSET_LAST = 12'hBFF;  // 3072 - 1
  localparam logic [12:0] CYCLE_LAST  = 13'h1F3F; // 8000 - 1
  localparam logic [31:0] CYCLE_TIME_RST = 32'h0000_0000;

  typedef struct packed {
    logic       is_write;
    logic [3:0] reg_index;
    logic [7:0] value;
  } snp_phy_req_s;

  typedef struct packed {
    logic [3:0] reg_index;
    logic [7:0] value;
  } snp_phy_rx_s;

  typedef struct packed {
    logic [6:0]  seconds;
    logic [12:0] cycles;
    logic [11:0] offset;
  } snp_cycle_time_s;

endpackage

// *** core/snp_regs.sv ***
// snp_regs: node address, phy register access and cycle time registers.
// assumes phy status, self-id and cycle start events come from link logic
// on the same clock as one-cycle pulses; register port on the same clock.
//
// How it works
// - bus reset clears valid; new node sets it
// - root flag taken from phy at self-id
// - cable power flag follows phy report
// - bus index writable, resets to all ones
// - node index loaded from phy, read-only
// - node id is bus and node index
// - reserved bits read as zero
// - request bit set clears read complete
// - phy register transfer sets read complete
// - capture received phy address and data
// - read request sent, then bit self-clears
// - write request sent, then bit self-clears
// - target index, write value; value unused for reads
// - cycle master sends current cycle time
// - non-master loads time from cycle start
// - timer keeps counting without cycle starts
// - offset counts modulo 3072, or with external source holds at 3071 until zeroed on external tick
// - cycles modulo 8000, seconds modulo 128
`timescale 1ns/1ns
module snp_regs
(
  input  wire logic                  clock,
  input  wire logic                  nrst,
  // register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata,
  // phy status and events
  input  wire logic                  bus_reset_seen,
  input  wire logic                  self_id_done,
  input  wire logic [5:0]            phy_node_num,
  input  wire logic                  phy_is_root,
  input  wire logic                  phy_cable_power_ok,
  input  wire logic                  phy_rx_valid,
  input  snp_pkg::snp_phy_rx_s       phy_rx,
  // phy register request
  output logic                       phy_req_valid,
  input  wire logic                  phy_req_ready,
  output snp_pkg::snp_phy_req_s      phy_req,
  // cycle timer control
  input  wire logic                  cycle_master_en,
  input  wire logic                  cycle_source_ext,
  input  wire logic                  cycle_timer_en,
  input  wire logic                  tick_24m,
  input  wire logic                  ext_cycle_tick,
  input  wire logic                  cs_rx_valid,
  input  wire logic [31:0]           cs_rx_data,
  output logic                       cs_tx_strobe,
  output logic [31:0]                cs_tx_data,
  // node identity
  output logic [15:0]                node_id,
  output logic                       node_id_valid,
  output logic                       async_transmit_blocked
);

  typedef struct packed {
    logic        valid;
    logic        root;
    logic        cable_power_ok;
    logic [9:0]  bus_index;
    logic [5:0]  node;
    logic        read_complete;
    logic [3:0]  rd_index;
    logic [7:0]  rd_value;
    logic        rd_req;
    logic        wr_req;
    logic [3:0]  tgt_index;
    logic [7:0]  wr_value;
    logic        tx_strobe;
    logic [31:0] tx_data;
    logic [31:0] rdata;
  } snp_regs_state_s;

  snp_regs_state_s        s_q;
  snp_regs_state_s        s_d;
  logic                   wr_node;
  logic                   wr_phy;
  logic                   wr_cycle;
  logic                   is_master;
  logic                   req_idle;
  logic                   req_sent;
  logic                   req_start;
  logic                   new_req;
  logic                   timer_roll;
  logic [31:0]            timer_value;
  logic [31:0]            node_word;
  logic [31:0]            phy_word;
  snp_pkg::snp_phy_req_s  start_req;

  // ==========================================================================
  // address decode
  assign wr_node  = reg_wr && (reg_addr == snp_pkg::OFS_NODE_ADDRESS);
  assign wr_phy   = reg_wr && (reg_addr == snp_pkg::OFS_PHY_ACCESS);
  assign wr_cycle = reg_wr && (reg_addr == snp_pkg::OFS_CYCLE_TIME);

  // cycle master only while the phy says this node is root
  assign is_master = cycle_master_en && s_q.root;

  // a request bit written while one is pending is dropped
  assign new_req = wr_phy
                   && (reg_wdata[snp_pkg::PA_RDREQ_BIT] || reg_wdata[snp_pkg::PA_WRREQ_BIT])
                   && !(s_q.rd_req || s_q.wr_req);

  // ==========================================================================
  // request launch toward the phy
  always_comb
  begin
    start_req           = '0;
    start_req.is_write  = s_q.wr_req && !s_q.rd_req;
    start_req.reg_index = s_q.tgt_index;
    start_req.value     = start_req.is_write ? s_q.wr_value : 8'h00;
  end

  assign req_start = (s_q.rd_req || s_q.wr_req) && req_idle;

  snp_phy_req u_phy_req
  (
    .clock     (clock),
    .nrst      (nrst),
    .start     (req_start),
    .start_req (start_req),
    .idle      (req_idle),
    .sent      (req_sent),
    .req_valid (phy_req_valid),
    .req_ready (phy_req_ready),
    .req       (phy_req)
  );

  // ==========================================================================
  // cycle timer
  snp_cycle_timer u_cycle_timer
  (
    .clock        (clock),
    .nrst         (nrst),
    .count_en     (cycle_timer_en),
    .tick         (tick_24m),
    .ext_source   (cycle_source_ext),
    .ext_tick_pin (ext_cycle_tick),
    .sw_load      (wr_cycle),
    .sw_value     (reg_wdata),
    .rx_load      (cs_rx_valid && !is_master),
    .rx_value     (cs_rx_data),
    .rollover     (timer_roll),
    .value        (timer_value)
  );

  // ==========================================================================
  // read words
  always_comb
  begin
    node_word                                         = 32'h0000_0000;
    node_word[snp_pkg::NA_VALID_BIT]                  = s_q.valid;
    node_word[snp_pkg::NA_ROOT_BIT]                   = s_q.root;
    node_word[snp_pkg::NA_POWER_BIT]                  = s_q.cable_power_ok;
    node_word[snp_pkg::NA_BUS_LSB +: 10]              = s_q.bus_index;
    node_word[snp_pkg::NA_NODE_LSB +: 6]              = s_q.node;
    phy_word                                          = 32'h0000_0000;
    phy_word[snp_pkg::PA_DONE_BIT]                    = s_q.read_complete;
    phy_word[snp_pkg::PA_RDIDX_LSB +: 4]              = s_q.rd_index;
    phy_word[snp_pkg::PA_RDVAL_LSB +: 8]              = s_q.rd_value;
    phy_word[snp_pkg::PA_RDREQ_BIT]                   = s_q.rd_req;
    phy_word[snp_pkg::PA_WRREQ_BIT]                   = s_q.wr_req;
    phy_word[snp_pkg::PA_TGT_LSB +: 4]                = s_q.tgt_index;
    phy_word[snp_pkg::PA_WRVAL_LSB +: 8]              = s_q.wr_value;
  end

  // ==========================================================================
  // next state
  always_comb
  begin
    s_d = s_q;

    // node address
    s_d.cable_power_ok = phy_cable_power_ok;
    if (wr_node)
      s_d.bus_index = reg_wdata[snp_pkg::NA_BUS_LSB +: 10];
    if (bus_reset_seen)
    begin
      s_d.valid = 1'b0;
      s_d.root  = 1'b0;
    end
    if (self_id_done)
    begin
      s_d.valid = 1'b1;
      s_d.root  = phy_is_root;
      s_d.node  = phy_node_num;
    end

    // phy register access
    if (wr_phy)
    begin
      s_d.tgt_index = reg_wdata[snp_pkg::PA_TGT_LSB +: 4];
      s_d.wr_value  = reg_wdata[snp_pkg::PA_WRVAL_LSB +: 8];
    end
    if (req_sent)
    begin
      s_d.rd_req = 1'b0;
      s_d.wr_req = 1'b0;
    end
    if (new_req)
    begin
      // read wins if software sets both
      s_d.rd_req        = reg_wdata[snp_pkg::PA_RDREQ_BIT];
      s_d.wr_req        = !reg_wdata[snp_pkg::PA_RDREQ_BIT];
      s_d.read_complete = 1'b0;
    end
    if (phy_rx_valid)
    begin
      s_d.read_complete = 1'b1;
      s_d.rd_index      = phy_rx.reg_index;
      s_d.rd_value      = phy_rx.value;
    end

    // cycle start transmit on each rollover while master
    s_d.tx_strobe = timer_roll && is_master;
    if (timer_roll && is_master)
      s_d.tx_data = timer_value;

    // read data, one cycle after the strobe
    s_d.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        snp_pkg::OFS_NODE_ADDRESS: s_d.rdata = node_word;
        snp_pkg::OFS_PHY_ACCESS:   s_d.rdata = phy_word;
        snp_pkg::OFS_CYCLE_TIME:   s_d.rdata = timer_value;
        default:                   s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q           <= '0;
      s_q.bus_index <= snp_pkg::BUS_INDEX_RST;
      s_q.node      <= snp_pkg::NODE_RST;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================================
  // outputs
  assign reg_rdata              = s_q.rdata;
  assign node_id                = {s_q.bus_index, s_q.node};
  assign node_id_valid          = s_q.valid;
  assign async_transmit_blocked = (s_q.node == snp_pkg::NODE_UNSET);
  assign cs_tx_strobe           = s_q.tx_strobe;
  assign cs_tx_data             = s_q.tx_data;

endmodule // snp_regs

// *** verification/snp_phy_model.sv ***
// snp_phy_model: phy end of the register request link, 16 registers.
// assumes requests held until ready; reads answered by a transfer.
`timescale 1ns/1ns
module snp_phy_model
(
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             phy_slow,
  input  wire logic             phy_req_valid,
  input  snp_pkg::snp_phy_req_s phy_req,
  output logic                  phy_req_ready,
  output logic                  phy_rx_valid,
  output snp_pkg::snp_phy_rx_s  phy_rx
);
  logic [7:0]  mem [16];
  logic [2:0]  wait_q;
  logic [2:0]  rsp_q;
  logic [3:0]  idx_q;
  logic [11:0] pat_q;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 16; i++)
        mem[i] <= 8'h00;
      {phy_req_ready, phy_rx_valid, wait_q, rsp_q, idx_q, pat_q} <= '0;
      phy_rx <= '0;
    end
    else
    begin
      pat_q <= pat_q + 12'h5A7;
      // no transfer: lines show a changing pattern
      phy_rx <= pat_q;
      phy_rx_valid <= 1'b0;
      if (phy_req_valid && phy_req_ready)
      begin
        phy_req_ready <= 1'b0;
        wait_q <= phy_slow ? 3'h5 : 3'h0;
        if (phy_req.is_write)
          mem[phy_req.reg_index] <= phy_req.value;
        else
          {idx_q, rsp_q} <= {phy_req.reg_index, 3'h3};
      end
      else if (phy_req_valid)
      begin
        if (wait_q != 3'h0)
          wait_q <= wait_q - 3'h1;
        else
          phy_req_ready <= 1'b1;
      end
      if (rsp_q != 3'h0)
        rsp_q <= rsp_q - 3'h1;
      if (rsp_q == 3'h1)
      begin
        phy_rx_valid <= 1'b1;
        phy_rx <= {idx_q, mem[idx_q]};
      end
    end
  end
endmodule // snp_phy_model

// *** verification/snp_regs_chk.sv ***
// snp_regs_chk: properties on the ports of snp_regs.
// assumes one clock domain; bound into every snp_regs.
`timescale 1ns/1ns
module snp_regs_chk
(
  input wire logic             clock,
  input wire logic             nrst,
  input wire logic [7:0]       reg_addr,
  input wire logic [31:0]      reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [31:0]      reg_rdata,
  input wire logic             bus_reset_seen,
  input wire logic             self_id_done,
  input wire logic [5:0]       phy_node_num,
  input wire logic             phy_cable_power_ok,
  input wire logic             phy_req_valid,
  input wire logic             phy_req_ready,
  input snp_pkg::snp_phy_req_s phy_req,
  input wire logic [15:0]      node_id,
  input wire logic             node_id_valid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic na_rd;
  logic pa_rd;
  logic pa_go;
  assign na_rd = reg_rd && reg_addr == 8'hE8;
  assign pa_rd = reg_rd && reg_addr == 8'hEC;
  assign pa_go = reg_wr && reg_addr == 8'hEC && reg_wdata[15:14] != 2'h0;

  AST_VALID_CLR: assert property (bus_reset_seen && !self_id_done |=> !node_id_valid)
    else $error("valid flag kept over bus reset");
  AST_VALID_SET: assert property (self_id_done && !bus_reset_seen |=> node_id_valid)
    else $error("valid flag not set by new node");
  AST_NODE_LOAD: assert property (self_id_done |=> node_id[5:0] == $past(phy_node_num))
    else $error("node index not loaded");
  AST_NODE_HOLD: assert property (!self_id_done |=> $stable(node_id[5:0]))
    else $error("node index moved without self id");
  AST_BUS_WR: assert property (reg_wr && reg_addr == 8'hE8 |=> node_id[15:6] == $past(reg_wdata[15:6]))
    else $error("bus index not written");
  AST_NA_READ: assert property (na_rd |=> reg_rdata[15:0] == $past(node_id)
    && reg_rdata[29:16] == {2'h0, $past(phy_cable_power_ok, 2), 11'h000} && reg_rdata[31] == $past(node_id_valid))
    else $error("node address read word wrong");
  AST_PA_RSVD: assert property (pa_rd |=> reg_rdata[30:28] == 3'h0 && reg_rdata[13:12] == 2'h0)
    else $error("reserved phy access bits set");
  AST_REQ_GO: assert property (pa_go && !phy_req_valid && !$past(pa_go) |-> ##2 phy_req_valid
    && phy_req == {!$past(reg_wdata[15], 2), $past(reg_wdata[11:8], 2),
    ($past(reg_wdata[15], 2) ? 8'h00 : $past(reg_wdata[7:0], 2))})
    else $error("phy request not issued as written");
  AST_REQ_HOLD: assert property (phy_req_valid && !phy_req_ready |=> phy_req_valid && $stable(phy_req))
    else $error("phy request changed before taken");
  AST_REQ_DROP: assert property (phy_req_valid && phy_req_ready |=> !phy_req_valid)
    else $error("phy request kept after taken");
endmodule // snp_regs_chk

bind snp_regs snp_regs_chk chk_u (.*);

// *** verification/tb_snp_regs.sv ***
// tb_snp_regs: random and corner tests of snp_regs against a phy model.
// assumes package, design, checker and phy model compiled before it.
`timescale 1ns/1ns
module tb_snp_regs;
  logic        clock, nrst, reg_wr, reg_rd, bus_reset_seen, self_id_done, phy_is_root;
  logic        phy_cable_power_ok, phy_rx_valid, phy_req_valid, phy_req_ready, phy_slow;
  logic        cycle_master_en, cycle_source_ext, cycle_timer_en, tick_24m, ext_cycle_tick;
  logic        cs_rx_valid, cs_tx_strobe, node_id_valid, async_transmit_blocked, rdq;
  logic [5:0]  phy_node_num;
  logic [7:0]  reg_addr, mir [16];
  logic [9:0]  bus;
  logic [15:0] node_id;
  logic [31:0] reg_wdata, reg_rdata, cs_rx_data, cs_tx_data, d, e, v, w;
  snp_pkg::snp_phy_rx_s  phy_rx;
  snp_pkg::snp_phy_req_s phy_req;
  int          errors, num_checks, i, k;

  snp_regs dut_u (.*);
  snp_phy_model phy_u (.*);

  always #25 clock = ~clock;

  // ==========================================
  // bus cycles and checks
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
    @(posedge clock);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    num_checks++;
    if (g !== x)
    begin
      errors++;
      $display("wrong value at %0t ns: %s got %h want %h", $time, m, g, x);
    end
  endtask
  task automatic tick(input int n);
    tick_24m <= 1'b1;
    repeat (n) @(posedge clock);
    tick_24m <= 1'b0;
  endtask
  function automatic logic [31:0] ct_next(input logic [31:0] t);
    snp_pkg::snp_cycle_time_s c;
    c = t;
    c.offset = (c.offset == 12'hBFF) ? 12'h000 : c.offset + 12'h001;
    if (c.offset == 12'h000)
    begin
      c.cycles = (c.cycles == 13'h1F3F) ? 13'h0000 : c.cycles + 13'h0001;
      if (c.cycles == 13'h0000)
        c.seconds = c.seconds + 7'h01;
    end
    return c;
  endfunction
  function automatic logic [31:0] rnd_ct();
    return {7'($urandom), 13'($urandom_range(0, 7999)), 12'($urandom_range(0, 3071))};
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #(50 * 40000);
    errors++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    final_report();
  end

  initial
  begin
    errors = 0;
    num_checks = 0;
    clock = 1'b0;
    {nrst, reg_wr, reg_rd, bus_reset_seen, self_id_done, phy_is_root, phy_cable_power_ok} = '0;
    {cycle_master_en, cycle_source_ext, cycle_timer_en, tick_24m, ext_cycle_tick, cs_rx_valid, phy_slow} = '0;
    {reg_addr, reg_wdata, phy_node_num, cs_rx_data} = '0;
    bus = 10'h3FF;
    for (i = 0; i < 16; i++)
      mir[i] = 8'h00;
    v = $urandom(64617);
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(8'hE8, d);
    chk(d, 32'h0000_FFC0, "node address reset");
    wr(8'hF4, $urandom);
    rd(8'hF4, d);
    chk(d, 32'h0, "unmapped read");
    $display("test reset done");

    for (i = 0; i < 5; i++)
    begin
      v[5:0] = (i == 0) ? 6'h3F : 6'($urandom_range(0, 62));
      v[6] = (i == 4) | 1'($urandom);
      phy_cable_power_ok <= 1'($urandom);
      bus_reset_seen <= 1'b1;
      @(posedge clock);
      bus_reset_seen <= 1'b0;
      rd(8'hE8, d);
      chk(d[31], 1'b0, "valid after bus reset");
      phy_node_num <= v[5:0];
      phy_is_root <= v[6];
      self_id_done <= 1'b1;
      @(posedge clock);
      self_id_done <= 1'b0;
      phy_node_num <= ~v[5:0];
      rd(8'hE8, d);
      e = {1'b1, v[6], 2'h0, phy_cable_power_ok, 11'h000, bus, v[5:0]};
      chk(d, e, "node address after self id");
      chk({node_id, async_transmit_blocked}, {bus, v[5:0], v[5:0] == 6'h3F}, "node id");
      w = $urandom;
      wr(8'hE8, w);
      bus = w[15:6];
      rd(8'hE8, d);
      chk(d, {e[31:16], bus, v[5:0]}, "bus index write");
    end
    $display("test node address done");

    for (i = 0; i < 10; i++)
    begin
      rdq = (i < 2) ? (i == 0) : 1'($urandom);
      k = $urandom_range(0, 15);
      v = $urandom;
      phy_slow <= 1'($urandom);
      wr(8'hEC, {16'h0, rdq, !rdq, 2'h0, 4'(k), v[7:0]});
      rd(8'hEC, d);
      chk({d[31], d[15:14]}, {1'b0, rdq, !rdq}, "request pending");
      for (int n = 0; n < 20 && d[15:14] != 2'h0; n++)
        rd(8'hEC, d);
      chk(d[15:14], 2'h0, "request bit self clears");
      if (rdq)
      begin
        for (int n = 0; n < 20 && !d[31]; n++)
          rd(8'hEC, d);
        chk(d[31:16], {4'h8, 4'(k), mir[k]}, "phy read result");
      end
      else
        mir[k] = v[7:0];
      chk(d[13:0], {2'h0, 4'(k), v[7:0]}, "target index and value");
    end
    $display("test phy access done");

    cycle_timer_en <= 1'b1;
    cycle_master_en <= 1'b1;
    v = {7'h7F, 13'h1F3F, 12'hBFF};
    wr(8'hF0, v);
    tick(1);
    e = 32'h1;
    for (int n = 0; n < 4; n++)
    begin
      #1 if (cs_tx_strobe === 1'b1) e = cs_tx_data;
      @(posedge clock);
    end
    chk(e, ct_next(v), "cycle start sent");
    for (i = 0; i < 2; i++)
    begin
      w = rnd_ct();
      cs_rx_data <= w;
      cs_rx_valid <= 1'b1;
      @(posedge clock);
      cs_rx_valid <= 1'b0;
      rd(8'hF0, d);
      chk(d, (i == 0) ? ct_next(v) : w, "cycle start load");
      cycle_master_en <= 1'b0;
    end
    for (i = 0; i < 24; i++)
    begin
      v = rnd_ct();
      if (i % 4 == 0)
        v[24:0] = {13'h1F3F, 12'hBFE};
      k = $urandom_range(1, 3);
      cycle_timer_en <= (i != 5);
      wr(8'hF0, v);
      tick(k);
      rd(8'hF0, d);
      for (int n = 0; n < k && i != 5; n++)
        v = ct_next(v);
      chk(d, v, "local cycle count");
    end
    cycle_source_ext <= 1'b1;
    wr(8'hF0, {7'h01, 13'h0005, 12'hBFD});
    tick(4);
    rd(8'hF0, d);
    chk(d, {7'h01, 13'h0005, 12'hBFF}, "offset holds for external tick");
    ext_cycle_tick <= 1'b1;
    repeat (6) @(posedge clock);
    ext_cycle_tick <= 1'b0;
    rd(8'hF0, d);
    chk(d, {7'h01, 13'h0006, 12'h000}, "external tick zeroes offset");
    $display("test cycle timer done");
    final_report();
  end
endmodule // tb_snp_regs
